// ==== rtl/afa_pkg.sv ====
// constants, types and helper functions for the channel buffer arithmetic
package afa_pkg;
  localparam int AFA_NCHAN = 8;
  localparam int AFA_CHW = 3;
  localparam int AFA_PTRW = 3;
  localparam int AFA_ACW = 3;
  localparam int AFA_BUFAW = 2;
  localparam logic [AFA_PTRW-1:0] AFA_BUF_DEPTH = 3'h4;
  localparam logic [AFA_ACW-1:0] AFA_AC_INIT = 3'h7;
  localparam logic [AFA_PTRW-1:0] AFA_PTR_RST = 3'h0;
  localparam logic [AFA_PTRW-1:0] AFA_PTR_STEP = 3'h1;
  // register map, byte offsets
  localparam logic [3:0] AFA_REG_CTRL = 4'h0;
  localparam logic [3:0] AFA_REG_STAT = 4'h4;
  localparam logic [3:0] AFA_REG_REQ = 4'h8;
  // ctrl field layout
  localparam int AFA_CTRL_EN_BIT = 0;
  localparam int AFA_CTRL_SEL_LSB = 4;
  localparam logic [31:0] AFA_CTRL_RST = 32'h0000_0001;
  // status field layout
  localparam int AFA_STAT_MPTR_LSB = 0;
  localparam int AFA_STAT_CPTR_LSB = 4;
  localparam int AFA_STAT_AC_LSB = 8;
  localparam int AFA_STAT_TOMEM_BIT = 12;
  localparam int AFA_STAT_DONE_BIT = 13;
  localparam int AFA_REQ_CCWF_LSB = 8;

  // per-channel state held in the control ram
  typedef struct packed {
    logic [AFA_PTRW-1:0] mem_ptr;
    logic [AFA_PTRW-1:0] ch_ptr;
    logic [AFA_ACW-1:0] act_cnt;
    logic to_mem;
    logic done;
  } afa_chan_s;

  localparam afa_chan_s AFA_CHAN_RST = '{AFA_PTR_RST, AFA_PTR_RST, AFA_AC_INIT, 1'b0, 1'b0};

  // which event drives the current ram cycle
  typedef enum logic [2:0] {
    AFA_EV_NONE, AFA_EV_INIT, AFA_EV_DONE, AFA_EV_MEM, AFA_EV_CMD, AFA_EV_WORD
  } afa_ev_e;

  // words held in the channel buffer, channel pointer ahead of memory pointer
  function automatic logic [AFA_PTRW-1:0] afa_ptr_diff(input logic [AFA_PTRW-1:0] mp,
                                                      input logic [AFA_PTRW-1:0] cp);
    afa_ptr_diff = cp - mp;
  endfunction

  // request equation: enough words (toward memory) or free slots for a group
  function automatic logic afa_req_eqn(input afa_chan_s s);
    logic [AFA_PTRW-1:0] avail;
    avail = s.to_mem ? afa_ptr_diff(s.mem_ptr, s.ch_ptr)
                   : AFA_BUF_DEPTH - afa_ptr_diff(s.ch_ptr, s.mem_ptr);
    if (s.act_cnt == AFA_AC_INIT || s.act_cnt == '0) begin
      afa_req_eqn = 1'b0;
    end else begin
      afa_req_eqn = (avail >= s.act_cnt);
    end
  endfunction
endpackage

// ==== rtl/afa_ram_if.sv ====
// control ram port bundle between the arithmetic core and its ram
`timescale 1ns/100ps
interface afa_ram_if;
  import afa_pkg::*;
  logic [AFA_CHW-1:0] rd_chan;
  afa_chan_s rd_data;
  logic [AFA_CHW-1:0] sel_chan;
  afa_chan_s sel_data;
  logic wr_en;
  logic [AFA_CHW-1:0] wr_chan;
  afa_chan_s wr_data;
  modport core (output rd_chan, input rd_data, output sel_chan, input sel_data,
                output wr_en, output wr_chan, output wr_data);
  modport ram (input rd_chan, output rd_data, input sel_chan, output sel_data,
               input wr_en, input wr_chan, input wr_data);
endinterface

// ==== rtl/afa_chan_ram.sv ====
// per-channel control ram for pointers and action count
`timescale 1ns/100ps
module afa_chan_ram
  import afa_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // ram port
  afa_ram_if.ram rp
);
  afa_chan_s mem_q [AFA_NCHAN];
  afa_chan_s mem_d [AFA_NCHAN];

  // next contents: one write per cycle
  always_comb begin
    for (int i = 0; i < AFA_NCHAN; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (rp.wr_en) begin
      mem_d[rp.wr_chan] = rp.wr_data;
    end
  end

  // storage, cleared to the idle channel state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < AFA_NCHAN; i++) begin
        mem_q[i] <= AFA_CHAN_RST;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  // asynchronous read ports
  assign rp.rd_data = mem_q[rp.rd_chan];
  assign rp.sel_data = mem_q[rp.sel_chan];
endmodule

// ==== rtl/afa_avs.sv ====
// avalon-mm register slave with one wait state
`timescale 1ns/100ps
module afa_avs
  import afa_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // block side
  output logic ctrl_en,
  output logic [AFA_CHW-1:0] ctrl_sel,
  input wire logic [31:0] stat_word,
  input wire logic [31:0] req_word
);
  logic wait_q, wait_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;
  logic take;

  // one wait cycle, then accept
  always_comb begin
    take = (avs_read || avs_write) && !wait_q;
    wait_d = !((avs_read || avs_write) && wait_q);
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    if (take && avs_write && avs_address == AFA_REG_CTRL && avs_byteenable[0]) begin
      ctrl_d[AFA_CTRL_EN_BIT] = avs_writedata[AFA_CTRL_EN_BIT];
      ctrl_d[AFA_CTRL_SEL_LSB +: AFA_CHW] = avs_writedata[AFA_CTRL_SEL_LSB +: AFA_CHW];
    end
    if (wait_q && avs_read) begin
      case (avs_address)
        AFA_REG_CTRL: rdata_d = ctrl_q;
        AFA_REG_STAT: rdata_d = stat_word;
        AFA_REG_REQ: rdata_d = req_word;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
      ctrl_q <= AFA_CTRL_RST;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= wait_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign ctrl_en = ctrl_q[AFA_CTRL_EN_BIT];
  assign ctrl_sel = ctrl_q[AFA_CTRL_SEL_LSB +: AFA_CHW];
endmodule

// ==== rtl/afa_top.sv ====
// channel buffer action flag arithmetic, top level
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps

// What this block does
// - memory transfers address the channel buffer with the memory pointer.
// - start or reset clears the channel's memory pointer to zero.
// - second ram cycle of a group request adds action count to memory pointer.
// - controller word transfers address the channel buffer with the channel pointer.
// - start or reset clears the channel's channel pointer to zero.
// - each word-transfer ram cycle increments the channel pointer by one.
// - group request enable comes from memory pointer, channel pointer, action count.
// - control cycle for start or interrupt reset: count seven, pointers zero.
// - right after initialization the group request enable stays clear.
// - after start, command words are fetched repeatedly through the block transfer.
// - command buffer write with opcode_load_strobe loads the new 3-bit action count; every write re-evaluates.
// - satisfied equation sets the group request enable, pending priority grant.
// - after a group moves, load new count, add to pointer, re-evaluate.
// - each controller word request moves exactly one word, then pointer steps.
// - enough words or free slots set the group request enable again.
// - done on controller-to-memory loads the pointer difference as action count.
module afa_top
  import afa_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // ram cycle strobes, one channel per cycle
  input wire logic [AFA_CHW-1:0] cycle_chan,
  input wire logic channel_start_command,
  input wire logic interrupt_reset_command,
  input wire logic start_to_mem,
  input wire logic command_buffer_write,
  input wire logic opcode_load_strobe,
  input wire logic [AFA_ACW-1:0] cmd_action_count,
  input wire logic word_count_zero,
  input wire logic memory_pointer_update_enable,
  input wire logic [AFA_ACW-1:0] mem_action_count,
  input wire logic word_transfer_request,
  input wire logic transfer_complete_signal,
  // channel data buffer addressing
  output logic [AFA_CHW+AFA_BUFAW-1:0] mem_buf_addr,
  output logic mem_buf_addr_vld,
  output logic [AFA_CHW+AFA_BUFAW-1:0] channel_data_buffer_addr,
  output logic channel_data_buffer_addr_vld,
  // request outputs
  output logic [AFA_NCHAN-1:0] group_transfer_request_enable,
  output logic [AFA_NCHAN-1:0] cmd_fetch_request,
  output logic channel_pointer_increment,
  output logic done_count_load,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  afa_ram_if rif ();

  afa_ev_e ev;
  afa_chan_s cur, nxt;
  logic [AFA_PTRW-1:0] pointer_difference;
  logic ctrl_en;
  logic [AFA_CHW-1:0] ctrl_sel;
  logic [31:0] stat_word, req_word;

  logic [AFA_NCHAN-1:0] af_q, af_d;
  logic [AFA_NCHAN-1:0] grp_q, grp_d;
  logic [AFA_NCHAN-1:0] ccwf_q, ccwf_d;
  logic [AFA_CHW+AFA_BUFAW-1:0] maddr_q, maddr_d, caddr_q, caddr_d;
  logic mvld_q, mvld_d, cvld_q, cvld_d;
  logic inc_q, inc_d, dload_q, dload_d;

  // control ram, one entry per channel
  afa_chan_ram u_ram (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .rp(rif.ram)
  );

  // register slave
  afa_avs u_avs (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ctrl_en(ctrl_en),
    .ctrl_sel(ctrl_sel),
    .stat_word(stat_word),
    .req_word(req_word)
  );

  // event priority for the current ram cycle
  always_comb begin
    if (channel_start_command || interrupt_reset_command) begin
      ev = AFA_EV_INIT;
    end else if (transfer_complete_signal) begin
      ev = AFA_EV_DONE;
    end else if (memory_pointer_update_enable) begin
      ev = AFA_EV_MEM;
    end else if (command_buffer_write) begin
      ev = AFA_EV_CMD;
    end else if (word_transfer_request) begin
      ev = AFA_EV_WORD;
    end else begin
      ev = AFA_EV_NONE;
    end
  end

  // read-modify-write of the cycle_chan channel's state, status read of the selected one
  assign rif.rd_chan = cycle_chan;
  assign rif.sel_chan = ctrl_sel;
  assign cur = rif.rd_data;
  assign pointer_difference = afa_ptr_diff(cur.mem_ptr, cur.ch_ptr);

  always_comb begin
    nxt = cur;
    case (ev)
      AFA_EV_INIT: begin
        nxt.act_cnt = AFA_AC_INIT;
        nxt.mem_ptr = AFA_PTR_RST;
        nxt.ch_ptr = AFA_PTR_RST;
        nxt.to_mem = start_to_mem;
        nxt.done = 1'b0;
      end
      AFA_EV_DONE: begin
        // draining only matters toward memory; the other way the buffer is empty
        if (cur.to_mem) begin
          nxt.done = 1'b1;
          nxt.act_cnt = pointer_difference;
        end
      end
      AFA_EV_MEM: begin
        nxt.mem_ptr = cur.mem_ptr + AFA_PTRW'(cur.act_cnt);
        // after done, keep loading what is still buffered
        nxt.act_cnt = cur.done ? afa_ptr_diff(nxt.mem_ptr, cur.ch_ptr) : mem_action_count;
      end
      AFA_EV_CMD: begin
        if (opcode_load_strobe) begin
          nxt.act_cnt = cmd_action_count;
        end
      end
      AFA_EV_WORD: begin
        nxt.ch_ptr = cur.ch_ptr + AFA_PTR_STEP;
      end
      default: begin
        nxt = cur;
      end
    endcase
  end

  assign rif.wr_en = (ev != AFA_EV_NONE);
  assign rif.wr_chan = cycle_chan;
  assign rif.wr_data = nxt;

  // request flags, buffer addresses and strobes
  always_comb begin
    af_d = af_q;
    ccwf_d = ccwf_q;
    maddr_d = maddr_q;
    caddr_d = caddr_q;
    mvld_d = 1'b0;
    cvld_d = 1'b0;
    inc_d = 1'b0;
    dload_d = 1'b0;
    if (ev != AFA_EV_NONE) begin
      af_d[cycle_chan] = afa_req_eqn(nxt);
    end
    if (channel_start_command) begin
      ccwf_d[cycle_chan] = 1'b1;
    end else if (command_buffer_write) begin
      ccwf_d[cycle_chan] = 1'b0;
    end else if (word_count_zero) begin
      ccwf_d[cycle_chan] = 1'b1;
    end
    if (ev == AFA_EV_MEM) begin
      maddr_d = {cycle_chan, cur.mem_ptr[AFA_BUFAW-1:0]};
      mvld_d = 1'b1;
    end
    if (ev == AFA_EV_WORD) begin
      caddr_d = {cycle_chan, cur.ch_ptr[AFA_BUFAW-1:0]};
      cvld_d = 1'b1;
      inc_d = 1'b1;
    end
    if (ev == AFA_EV_DONE && cur.to_mem) begin
      dload_d = 1'b1;
    end
    grp_d = af_d & {AFA_NCHAN{ctrl_en}};
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      af_q <= '0;
      grp_q <= '0;
      ccwf_q <= '0;
      maddr_q <= '0;
      caddr_q <= '0;
      mvld_q <= 1'b0;
      cvld_q <= 1'b0;
      inc_q <= 1'b0;
      dload_q <= 1'b0;
    end else begin
      af_q <= af_d;
      grp_q <= grp_d;
      ccwf_q <= ccwf_d;
      maddr_q <= maddr_d;
      caddr_q <= caddr_d;
      mvld_q <= mvld_d;
      cvld_q <= cvld_d;
      inc_q <= inc_d;
      dload_q <= dload_d;
    end
  end

  // status words for software
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[AFA_STAT_MPTR_LSB +: AFA_PTRW] = rif.sel_data.mem_ptr;
    stat_word[AFA_STAT_CPTR_LSB +: AFA_PTRW] = rif.sel_data.ch_ptr;
    stat_word[AFA_STAT_AC_LSB +: AFA_ACW] = rif.sel_data.act_cnt;
    stat_word[AFA_STAT_TOMEM_BIT] = rif.sel_data.to_mem;
    stat_word[AFA_STAT_DONE_BIT] = rif.sel_data.done;
    req_word = 32'h0000_0000;
    req_word[AFA_NCHAN-1:0] = af_q;
    req_word[AFA_REQ_CCWF_LSB +: AFA_NCHAN] = ccwf_q;
  end

  assign group_transfer_request_enable = grp_q;
  assign cmd_fetch_request = ccwf_q;
  assign mem_buf_addr = maddr_q;
  assign mem_buf_addr_vld = mvld_q;
  assign channel_data_buffer_addr = caddr_q;
  assign channel_data_buffer_addr_vld = cvld_q;
  assign channel_pointer_increment = inc_q;
  assign done_count_load = dload_q;
endmodule

// ==== verification/afa_top_properties.sv ====
// port assertions for the channel buffer arithmetic
`timescale 1ns/100ps
module afa_top_properties
  import afa_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // strobes
  input wire logic [AFA_CHW-1:0] cycle_chan,
  input wire logic channel_start_command,
  input wire logic interrupt_reset_command,
  input wire logic command_buffer_write,
  input wire logic memory_pointer_update_enable,
  input wire logic word_transfer_request,
  input wire logic transfer_complete_signal,
  // outputs
  input wire logic [AFA_CHW+AFA_BUFAW-1:0] channel_data_buffer_addr,
  input wire logic channel_data_buffer_addr_vld,
  input wire logic mem_buf_addr_vld,
  input wire logic [AFA_NCHAN-1:0] group_transfer_request_enable,
  input wire logic channel_pointer_increment,
  input wire logic done_count_load
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // start or interrupt reset cycle
  sequence s_init;
    channel_start_command || interrupt_reset_command;
  endsequence
  // memory update with nothing of higher rank
  sequence s_mem;
    memory_pointer_update_enable && !channel_start_command && !interrupt_reset_command
      && !transfer_complete_signal;
  endsequence
  // word request with nothing of higher rank
  sequence s_word;
    word_transfer_request && !channel_start_command && !interrupt_reset_command
      && !transfer_complete_signal && !memory_pointer_update_enable && !command_buffer_write;
  endsequence
  chk_word_step: assert property (s_word |=> channel_data_buffer_addr_vld && channel_pointer_increment)
    else $error("word cycle gave no pointer step");
  chk_word_chan: assert property (s_word |=>
    channel_data_buffer_addr[AFA_CHW+AFA_BUFAW-1:AFA_BUFAW] == $past(cycle_chan))
    else $error("channel address carries wrong channel");
  chk_inc_pair: assert property (channel_data_buffer_addr_vld == channel_pointer_increment)
    else $error("increment and address valid disagree");
  chk_vld_cause: assert property (channel_data_buffer_addr_vld |-> $past(word_transfer_request))
    else $error("channel address without word request");
  chk_mem_step: assert property (s_mem |=> mem_buf_addr_vld)
    else $error("memory update gave no memory address");
  chk_init_quiet: assert property (s_init |=> !channel_data_buffer_addr_vld && !mem_buf_addr_vld
    && !done_count_load) else $error("init cycle moved a pointer");
  chk_init_clear: assert property (s_init |=>
    !group_transfer_request_enable[$past(cycle_chan)])
    else $error("group request set after init");
  chk_done_cause: assert property (done_count_load |-> $past(transfer_complete_signal))
    else $error("count load without done");
endmodule

// ==== verification/afa_ctl_model.sv ====
// channel controller model: word requests then optional done
`timescale 1ns/100ps
module afa_ctl_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // bench commands
  input wire logic go,
  input wire logic [2:0] n_words,
  input wire logic fin,
  input wire logic slow,
  // controller side
  output logic word_transfer_request,
  output logic transfer_complete_signal,
  output logic busy
);
  logic [2:0] left;
  logic fin_q;
  logic pace;
  assign busy = (left != 3'h0) || fin_q || word_transfer_request || transfer_complete_signal;
  // one pulse per word, done only once the last word went
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      left <= 3'h0;
      fin_q <= 1'h0;
      pace <= 1'h0;
      word_transfer_request <= 1'h0;
      transfer_complete_signal <= 1'h0;
    end else begin
      pace <= !pace;
      word_transfer_request <= 1'h0;
      transfer_complete_signal <= 1'h0;
      if (go) begin
        left <= n_words;
        fin_q <= fin;
      end else if (left != 3'h0) begin
        if (!slow || pace) begin
          word_transfer_request <= 1'h1;
          left <= left - 3'h1;
        end
      end else if (fin_q && !word_transfer_request) begin
        transfer_complete_signal <= 1'h1;
        fin_q <= 1'h0;
      end
    end
  end
endmodule

// ==== verification/afa_top_test.sv ====
// self-checking bench for the channel buffer arithmetic
`timescale 1ns/100ps
module afa_top_test;
  import afa_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic [2:0] cycle_chan = 3'h0, cmd_action_count = 3'h0, mem_action_count = 3'h0, n_words = 3'h0;
  logic channel_start_command = 1'h0, interrupt_reset_command = 1'h0, start_to_mem = 1'h0;
  logic command_buffer_write = 1'h0, opcode_load_strobe = 1'h0, word_count_zero = 1'h0;
  logic memory_pointer_update_enable = 1'h0, go = 1'h0, fin = 1'h0, slow = 1'h0, busy;
  logic word_transfer_request, transfer_complete_signal, mem_buf_addr_vld, channel_data_buffer_addr_vld;
  logic channel_pointer_increment, done_count_load, avs_waitrequest;
  logic avs_read = 1'h0, avs_write = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic [4:0] mem_buf_addr, channel_data_buffer_addr, exp_ch[$], exp_mem[$];
  logic [7:0] group_transfer_request_enable, cmd_fetch_request;
  logic [2:0] c, ac, n;
  int err_total = 0, samples_checked = 0, done_seen = 0, i;
  integer seed = 90;
  always #12.5 ref_clk = ~ref_clk;
  afa_top u_afa_top (.ref_clk(ref_clk), .rst_b(rst_b), .cycle_chan(cycle_chan),
    .channel_start_command(channel_start_command),
    .interrupt_reset_command(interrupt_reset_command), .start_to_mem(start_to_mem),
    .command_buffer_write(command_buffer_write), .opcode_load_strobe(opcode_load_strobe),
    .cmd_action_count(cmd_action_count), .word_count_zero(word_count_zero),
    .memory_pointer_update_enable(memory_pointer_update_enable),
    .mem_action_count(mem_action_count), .word_transfer_request(word_transfer_request),
    .transfer_complete_signal(transfer_complete_signal), .mem_buf_addr(mem_buf_addr),
    .mem_buf_addr_vld(mem_buf_addr_vld), .channel_data_buffer_addr(channel_data_buffer_addr),
    .channel_data_buffer_addr_vld(channel_data_buffer_addr_vld), .cmd_fetch_request(cmd_fetch_request),
    .group_transfer_request_enable(group_transfer_request_enable),
    .channel_pointer_increment(channel_pointer_increment), .done_count_load(done_count_load),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  afa_ctl_model u_afa_ctl_model (.ref_clk(ref_clk), .rst_b(rst_b), .go(go),
    .n_words(n_words), .fin(fin), .slow(slow), .word_transfer_request(word_transfer_request),
    .transfer_complete_signal(transfer_complete_signal), .busy(busy));
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and stop
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // bounded wait until busy (use_busy high) or waitrequest is seen low at an edge
  task automatic wait_low(input bit use_busy);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while ((use_busy ? busy : avs_waitrequest) !== 1'h0 && k < 40);
    if ((use_busy ? busy : avs_waitrequest) !== 1'h0) begin
      err_total++;
      end_of_test();
    end
  endtask
  // avalon access held until waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    wait_low(1'h0);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  // select a channel and read its status word
  task automatic rstat(input logic [2:0] ch);
    bus(1'h1, AFA_REG_CTRL, 32'h0000_0001 | (32'(ch) << AFA_CTRL_SEL_LSB));
    bus(1'h0, AFA_REG_STAT, 32'h0000_0000);
  endtask
  // one strobe cycle: 0 start, 1 reset, 2 command, 3 memory update, else fetch
  task automatic pulse(input logic [2:0] ch, input int kind, input logic [2:0] v);
    @(posedge ref_clk);
    cycle_chan <= ch;
    cmd_action_count <= v;
    mem_action_count <= v;
    case (kind)
      0: channel_start_command <= 1'h1;
      1: interrupt_reset_command <= 1'h1;
      2: {command_buffer_write, opcode_load_strobe} <= 2'h3;
      3: memory_pointer_update_enable <= 1'h1;
      default: word_count_zero <= 1'h1;
    endcase
    @(posedge ref_clk);
    {channel_start_command, interrupt_reset_command, command_buffer_write} <= 3'h0;
    {opcode_load_strobe, memory_pointer_update_enable, word_count_zero} <= 3'h0;
    @(posedge ref_clk);
  endtask
  // controller moves nw words, noting each expected buffer slot
  task automatic words(input logic [2:0] ch, input logic [2:0] nw, input logic [1:0] p0,
                       input logic f, input logic s);
    for (int k = 0; k < nw; k++) exp_ch.push_back({ch, p0 + 2'(k)});
    @(posedge ref_clk);
    cycle_chan <= ch;
    {go, fin, slow} <= {1'h1, f, s};
    n_words <= nw;
    @(posedge ref_clk);
    go <= 1'h0;
    repeat (2) @(posedge ref_clk);
    wait_low(1'h1);
    repeat (2) @(posedge ref_clk);
  endtask
  // buffer address monitor against the noted expectations
  always @(posedge ref_clk) begin
    if (done_count_load === 1'h1) done_seen++;
    if (channel_data_buffer_addr_vld === 1'h1) begin
      if (exp_ch.size() == 0) chk("ch addr extra", 1, 0);
      else chk("channel_data_buffer_addr", 32'(channel_data_buffer_addr), 32'(exp_ch.pop_front()));
    end
    if (mem_buf_addr_vld === 1'h1) begin
      if (exp_mem.size() == 0) chk("mem addr extra", 1, 0);
      else chk("mem_buf_addr", 32'(mem_buf_addr), 32'(exp_mem.pop_front()));
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'h1;
    rstat(3'h0);
    chk("reset status", rd, 32'h0000_0700);
    bus(1'h0, 4'hc, 32'h0000_0000);
    chk("unmapped read", rd, 32'h0000_0000);
    $display("test reset done");
    start_to_mem <= 1'h1;
    pulse(3'h2, 0, 3'h0);
    chk("grp after start", group_transfer_request_enable[2], 1'h0);
    chk("fetch after start", cmd_fetch_request[2], 1'h1);
    rstat(3'h2);
    chk("start status", rd, 32'h0000_1700);
    pulse(3'h2, 2, 3'h2);
    chk("fetch cleared", cmd_fetch_request[2], 1'h0);
    chk("grp empty buf", group_transfer_request_enable[2], 1'h0);
    words(3'h2, 3'h2, 2'h0, 1'h0, 1'h0);
    chk("grp two words", group_transfer_request_enable[2], 1'h1);
    exp_mem.push_back(5'h08);
    pulse(3'h2, 3, 3'h2);
    chk("grp after group", group_transfer_request_enable[2], 1'h0);
    rstat(3'h2);
    chk("group status", rd, 32'h0000_1222);
    pulse(3'h2, 4, 3'h0);
    chk("fetch again", cmd_fetch_request[2], 1'h1);
    words(3'h2, 3'h1, 2'h2, 1'h1, 1'h1);
    chk("done loads", done_seen, 1);
    chk("grp drain", group_transfer_request_enable[2], 1'h1);
    rstat(3'h2);
    chk("done status", rd, 32'h0000_3132);
    exp_mem.push_back(5'h0a);
    pulse(3'h2, 3, 3'h3);
    rstat(3'h2);
    chk("drained status", rd, 32'h0000_3033);
    $display("test to-memory done");
    start_to_mem <= 1'h0;
    for (i = 0; i < 3; i++) begin
      c = 3'($random(seed));
      if (c == 3'h2) c = 3'h5;
      ac = 3'(($random(seed) & 3) + 1);
      n = 3'(($random(seed) & 1) + 1);
      pulse(c, 0, 3'h0);
      pulse(c, 2, ac);
      chk("grp free slots", group_transfer_request_enable[c], 1'h1);
      words(c, n, 2'h0, 1'h0, 1'(i));
      rstat(c);
      chk("word status", rd, (32'(n) << 4) | (32'(ac) << 8));
      pulse(c, 1, 3'h0);
      rstat(c);
      chk("interrupt_reset_command status", rd, 32'h0000_0700);
      chk("grp interrupt_reset_command", group_transfer_request_enable[c], 1'h0);
    end
    rstat(3'h2);
    chk("other channel kept", rd, 32'h0000_3033);
    chk("words pending", exp_ch.size() + exp_mem.size(), 0);
    $display("test channels done");
    end_of_test();
  end
endmodule
bind afa_top afa_top_properties u_afa_top_properties (.ref_clk(ref_clk), .rst_b(rst_b),
  .cycle_chan(cycle_chan), .channel_start_command(channel_start_command),
  .interrupt_reset_command(interrupt_reset_command),
  .command_buffer_write(command_buffer_write),
  .memory_pointer_update_enable(memory_pointer_update_enable),
  .word_transfer_request(word_transfer_request),
  .transfer_complete_signal(transfer_complete_signal), .channel_data_buffer_addr(channel_data_buffer_addr),
  .channel_data_buffer_addr_vld(channel_data_buffer_addr_vld), .mem_buf_addr_vld(mem_buf_addr_vld),
  .group_transfer_request_enable(group_transfer_request_enable),
  .channel_pointer_increment(channel_pointer_increment), .done_count_load(done_count_load));
